/* File: hdl/ssb_sram.sv */
/*
 * command, burst and data path of a burst-of-two common-io sram.
 * assumes pin clock edges arrive as one-cycle strobes synchronous to CLK,
 * never two strobes of one pair in the same cycle, at least two CLK apart.
 */
// Notes on behaviour
// - second burst address made internally
// - low address bit flips for second beat
// - load low, select high means read
// - load low, select low means write
// - address captured only when load low
// - load high: nothing happens, bus floats
// - read beats on complement then true edge
// - write beats next main, then complement edge
// - two strobes gate two nine-bit lanes
// - four strobes gate four nine-bit lanes
// - clock stopped: outputs keep previous state
// - output clocks high: main pair times reads
// - recent writes visible to following reads
// - free-running echo clocks track read data
`timescale 1ns/1ns
`default_nettype none
module ssb_sram
   import ssb_pkg::*;
#(
   parameter int DATA_W = SSB_DATA_W,
   parameter int LANES = DATA_W / SSB_LANE_W
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic K_RISE,
   input wire logic KN_RISE,
   input wire logic C_RISE,
   input wire logic CN_RISE,
   input wire logic OUT_CLK_HIGH,
   input wire logic LOAD_N,
   input wire logic RW_SEL,
   input wire logic [SSB_ADDR_W-1:0] ADDR,
   input wire logic [LANES-1:0] BYTE_STROBE_N,
   input wire logic [DATA_W-1:0] DQ_I,
   output logic [DATA_W-1:0] DQ_O,
   output logic DQ_OE_N,
   output logic ECHO_CLK,
   output logic ECHO_CLK_N
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   ssb_burst_t rd_cmd_q;
   ssb_burst_t wr_cmd_q;
   logic rd_late_q;
   logic wr_beat2_q;
   logic [1:0] rd_tag_q;
   logic [DATA_W-1:0] hold0_q;
   logic [DATA_W-1:0] hold1_q;
   logic [DATA_W-1:0] rd_data;
   ssb_out_state_t out_q;
   logic out_t;
   logic out_c;
   logic load;
   logic [LANES-1:0] mem_we;
   logic [SSB_ADDR_W-1:0] mem_waddr;
   logic mem_re;
   logic [SSB_ADDR_W-1:0] mem_raddr;
   logic [1:0] rd_tag_d;

   // output edges: main pair stands in when both output clocks sit high
   assign out_t = OUT_CLK_HIGH ? K_RISE : C_RISE;
   assign out_c = OUT_CLK_HIGH ? KN_RISE : CN_RISE;
   assign load = K_RISE && !LOAD_N;

   // ----------------------------------------------------------------
   // command capture
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         rd_cmd_q <= '0;
         wr_cmd_q <= '0;
         rd_late_q <= 1'h0;
      end else if (K_RISE) begin
         rd_cmd_q.vld <= load && RW_SEL;
         wr_cmd_q.vld <= load && !RW_SEL;
         if (load) begin
            rd_cmd_q.addr <= ADDR;
            wr_cmd_q.addr <= ADDR;
         end
         rd_late_q <= rd_cmd_q.vld;
      end
   end

   // ----------------------------------------------------------------
   // write path
   // ----------------------------------------------------------------
   // strobes are taken per beat; all high gives an empty lane mask
   always_comb begin
      mem_we = '0;
      mem_waddr = wr_cmd_q.addr;
      if (K_RISE && wr_cmd_q.vld) begin
         mem_we = ~BYTE_STROBE_N;
      end else if (KN_RISE && wr_beat2_q) begin
         mem_we = ~BYTE_STROBE_N;
         mem_waddr = ssb_next_addr(wr_cmd_q.addr);
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         wr_beat2_q <= 1'h0;
      end else if (K_RISE) begin
         wr_beat2_q <= wr_cmd_q.vld;
      end else if (KN_RISE) begin
         wr_beat2_q <= 1'h0;
      end
   end

   // ----------------------------------------------------------------
   // read fetch
   // ----------------------------------------------------------------
   // fetch early so that the data are ready well before the output edge
   always_comb begin
      mem_re = 1'h0;
      mem_raddr = rd_cmd_q.addr;
      rd_tag_d = SSB_TAG_NONE;
      if (KN_RISE && rd_cmd_q.vld) begin
         mem_re = 1'h1;
         rd_tag_d = SSB_TAG_B1;
      end else if (K_RISE && rd_cmd_q.vld) begin
         mem_re = 1'h1;
         mem_raddr = ssb_next_addr(rd_cmd_q.addr);
         rd_tag_d = SSB_TAG_B2;
      end
   end

   ssb_mem #(
      .ADDR_W(SSB_ADDR_W),
      .DATA_W(DATA_W),
      .LANE_W(SSB_LANE_W),
      .LANES(LANES)
   ) u_mem (
      .clk(CLK),
      .wr_en(mem_we),
      .wr_addr(mem_waddr),
      .wr_data(DQ_I),
      .rd_en(mem_re),
      .rd_addr(mem_raddr),
      .rd_data_q(rd_data)
   );

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         rd_tag_q <= SSB_TAG_NONE;
      end else begin
         rd_tag_q <= rd_tag_d;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         hold0_q <= '0;
         hold1_q <= '0;
      end else if (rd_tag_q == SSB_TAG_B1) begin
         hold0_q <= rd_data;
      end else if (rd_tag_q == SSB_TAG_B2) begin
         hold1_q <= rd_data;
      end
   end

   // ----------------------------------------------------------------
   // output sequencer
   // ----------------------------------------------------------------
   // with no edges nothing moves, so a stopped clock freezes the bus
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         out_q <= SSB_OUT_IDLE;
         DQ_O <= '0;
         DQ_OE_N <= SSB_OE_N_RST;
      end else begin
         case (out_q)
            SSB_OUT_IDLE: begin
               if (out_c && rd_late_q) begin
                  out_q <= SSB_OUT_BEAT1;
                  DQ_O <= hold0_q;
                  DQ_OE_N <= 1'h0;
               end
            end
            SSB_OUT_BEAT1: begin
               if (out_t) begin
                  out_q <= SSB_OUT_BEAT2;
                  DQ_O <= hold1_q;
               end
            end
            SSB_OUT_BEAT2: begin
               if (out_c && rd_late_q) begin
                  out_q <= SSB_OUT_BEAT1;
                  DQ_O <= hold0_q;
               end else if (out_c) begin
                  out_q <= SSB_OUT_IDLE;
                  DQ_OE_N <= 1'h1;
               end
            end
            default: begin
               out_q <= SSB_OUT_IDLE;
               DQ_OE_N <= 1'h1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // echo clocks
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ECHO_CLK <= SSB_ECHO_RST;
         ECHO_CLK_N <= ~SSB_ECHO_RST;
      end else if (out_t) begin
         ECHO_CLK <= 1'h1;
         ECHO_CLK_N <= 1'h0;
      end else if (out_c) begin
         ECHO_CLK <= 1'h0;
         ECHO_CLK_N <= 1'h1;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   sequence s_read_cmd;
      K_RISE && !LOAD_N && RW_SEL;
   endsequence
   sequence s_beat1_go;
      out_c && rd_late_q && (out_q != SSB_OUT_BEAT1);
   endsequence

   a_read_decode: assert property (s_read_cmd |=> rd_cmd_q.vld && !wr_cmd_q.vld)
      else $error("read command not registered");
   a_write_decode: assert property (K_RISE && !LOAD_N && !RW_SEL |=> wr_cmd_q.vld)
      else $error("write command not registered");
   a_idle_no_load: assert property (
      K_RISE && LOAD_N |=> !rd_cmd_q.vld && !wr_cmd_q.vld && $stable(rd_cmd_q.addr))
      else $error("idle slot captured a command");
   a_burst_second: assert property (
      rd_tag_d == SSB_TAG_B2 |-> mem_raddr[0] != rd_cmd_q.addr[0]
      && mem_raddr[SSB_ADDR_W-1:1] == rd_cmd_q.addr[SSB_ADDR_W-1:1])
      else $error("second burst address wrong");
   a_beat1_drive: assert property (
      s_beat1_go |=> out_q == SSB_OUT_BEAT1 && !DQ_OE_N && DQ_O == $past(hold0_q))
      else $error("first read beat not driven");
   a_beat2_drive: assert property (
      out_q == SSB_OUT_BEAT1 && out_t |=> out_q == SSB_OUT_BEAT2 && DQ_O == $past(hold1_q))
      else $error("second read beat not driven");
   a_idle_float: assert property (out_q == SSB_OUT_IDLE |-> DQ_OE_N)
      else $error("bus driven with no read");
   a_stop_hold: assert property (
      !(K_RISE || KN_RISE || C_RISE || CN_RISE) |=> $stable(DQ_O) && $stable(DQ_OE_N))
      else $error("outputs moved with clocks stopped");
   a_echo_track: assert property (out_t |=> ECHO_CLK && !ECHO_CLK_N)
      else $error("echo clock not following output edge");
   a_strobe_abort: assert property ((K_RISE || KN_RISE) && &BYTE_STROBE_N |-> mem_we == '0)
      else $error("write with all strobes high");
   a_single_clk: assert property (
      OUT_CLK_HIGH && KN_RISE && rd_late_q && out_q != SSB_OUT_BEAT1 |=> !DQ_OE_N)
      else $error("main pair did not time read");
   a_fetch_read: assert property (
      KN_RISE && rd_cmd_q.vld |-> (mem_re && mem_raddr == rd_cmd_q.addr)
      ##1 (rd_tag_q == SSB_TAG_B1))
      else $error("read fetch missing");
endmodule // ssb_sram
`default_nettype wire

/* File: hdl/ssb_pkg.sv */
/*
 * constants, carriers and helpers shared by the burst-of-two sram model.
 * assumes one system clock with clock edges of the memory pins arriving as strobes.
 */
package ssb_pkg;
   // ----------------------------------------------------------------
   // organisation
   // ----------------------------------------------------------------
   localparam int SSB_ADDR_W = 21;
   localparam int SSB_DATA_W = 36;
   localparam int SSB_LANE_W = 9;

   // ----------------------------------------------------------------
   // read tags and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] SSB_TAG_NONE = 2'h0;
   localparam logic [1:0] SSB_TAG_B1 = 2'h1;
   localparam logic [1:0] SSB_TAG_B2 = 2'h2;
   localparam logic SSB_OE_N_RST = 1'h1;
   localparam logic SSB_ECHO_RST = 1'h0;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic vld;
      logic [SSB_ADDR_W-1:0] addr;
   } ssb_burst_t;

   typedef enum logic [2:0] {
      SSB_OUT_IDLE = 3'h1,
      SSB_OUT_BEAT1 = 3'h2,
      SSB_OUT_BEAT2 = 3'h4
   } ssb_out_state_t;

   // second burst address: low bit flips, upper bits kept
   function automatic logic [SSB_ADDR_W-1:0] ssb_next_addr(input logic [SSB_ADDR_W-1:0] a);
      return {a[SSB_ADDR_W-1:1], ~a[0]};
   endfunction
endpackage

/* File: hdl/ssb_mem.sv */
/*
 * byte-lane memory array with registered read data.
 * assumes at most one write and one read per clock; a read that meets a
 * write to the same word sees the new lanes.
 */
`timescale 1ns/1ns
`default_nettype none
module ssb_mem #(
   parameter int ADDR_W = 21,
   parameter int DATA_W = 36,
   parameter int LANE_W = 9,
   parameter int LANES = DATA_W / LANE_W
) (
   input wire logic clk,
   input wire logic [LANES-1:0] wr_en,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic rd_en,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [DATA_W-1:0] rd_data_q
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // ----------------------------------------------------------------
   // array and forwarding
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      for (int i = 0; i < LANES; i++) begin
         if (wr_en[i]) begin
            mem[wr_addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
         end
         if (rd_en) begin
            if (wr_en[i] && (wr_addr == rd_addr)) begin
               rd_data_q[i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
            end else begin
               rd_data_q[i*LANE_W +: LANE_W] <= mem[rd_addr][i*LANE_W +: LANE_W];
            end
         end
      end
   end
endmodule // ssb_mem
`default_nettype wire

/* File: verification/ssb_ctrl_model.sv */
/* controller model: pin clock strobes, commands and write data.
   assumes the sram samples every input on the rising edge of clk. */
`timescale 1ns/1ns
`default_nettype none
module ssb_ctrl_model
   import ssb_pkg::*;
(
   input wire logic clk,
   input wire logic run,
   input wire logic och,
   output logic k_rise,
   output logic kn_rise,
   output logic c_rise,
   output logic cn_rise,
   output logic load_n,
   output logic rw_sel,
   output logic [SSB_ADDR_W-1:0] addr,
   output logic [3:0] strobe_n,
   output logic [SSB_DATA_W-1:0] dq
);
   // ------------------------------------------------------------
   // pin clocks: k 0, c 2, kn 4, cn 6; c/cn frozen while tied high
   // ------------------------------------------------------------
   logic [2:0] ph_q = 3'h0;
   initial begin
      {k_rise, kn_rise, c_rise, cn_rise, load_n, rw_sel} = 6'h03;
      addr = '0;
      strobe_n = 4'hf;
      dq = '0;
   end
   always @(posedge clk) begin
      ph_q <= ph_q + 3'h1;
      k_rise <= run && ph_q == 3'h7;
      kn_rise <= run && ph_q == 3'h3;
      c_rise <= run && !och && ph_q == 3'h1;
      cn_rise <= run && !och && ph_q == 3'h5;
   end
   task automatic wait_ph(input logic [2:0] p);
      @(posedge clk);
      for (int i = 0; i < 8 && ph_q != p; i++) @(posedge clk);
   endtask
   // one burst slot; the k slot after it stays empty
   task automatic burst(input logic ld, input logic rd, input logic [SSB_ADDR_W-1:0] a,
                        input logic [SSB_DATA_W-1:0] d0, input logic [SSB_DATA_W-1:0] d1,
                        input logic [3:0] s0, input logic [3:0] s1);
      wait_ph(3'h7);
      load_n <= ld;
      rw_sel <= rd;
      addr <= a;
      @(posedge clk);
      load_n <= 1'h1;
      rw_sel <= ~rd;
      addr <= ~a;
      wait_ph(3'h7);
      if (!rd) begin
         dq <= d0;
         strobe_n <= ld ? 4'hf : s0;
         wait_ph(3'h3);
         dq <= d1;
         strobe_n <= ld ? 4'hf : s1;
         @(posedge clk);
      end
      // released bus shows the inverse, never a stale copy
      dq <= ~dq;
      strobe_n <= 4'hf;
   endtask
endmodule // ssb_ctrl_model
`default_nettype wire

/* File: verification/tb.sv */
/* self-checking bench of the burst-of-two sram.
   assumes ssb_pkg and the sram with its 36-bit default organisation. */
`timescale 1ns/1ns
`default_nettype none
module tb;
   import ssb_pkg::*;
   // ------------------------------------------------------------
   // wiring
   // ------------------------------------------------------------
   logic clk, sys_rst, run, och, k_rise, kn_rise, c_rise, cn_rise, load_n, rw_sel;
   logic dq_oe_n, echo, echo_n, stb_q, tru_q;
   logic [SSB_ADDR_W-1:0] addr, a0;
   logic [3:0] strobe_n;
   logic [SSB_DATA_W-1:0] dq_i, dq_o, snap, d;
   logic [SSB_DATA_W-1:0] exp_q[$];
   logic [SSB_DATA_W-1:0] ref_mem[int];
   int miscompares = 0;
   int num_checks = 0;
   int seed = 32'h3ee30244;
   ssb_sram i_dut (.CLK(clk), .SYS_RST(sys_rst), .K_RISE(k_rise), .KN_RISE(kn_rise),
      .C_RISE(c_rise), .CN_RISE(cn_rise), .OUT_CLK_HIGH(och), .LOAD_N(load_n),
      .RW_SEL(rw_sel), .ADDR(addr), .BYTE_STROBE_N(strobe_n), .DQ_I(dq_i), .DQ_O(dq_o),
      .DQ_OE_N(dq_oe_n), .ECHO_CLK(echo), .ECHO_CLK_N(echo_n));
   ssb_ctrl_model i_ctrl (.clk(clk), .run(run), .och(och), .k_rise(k_rise),
      .kn_rise(kn_rise), .c_rise(c_rise), .cn_rise(cn_rise), .load_n(load_n),
      .rw_sel(rw_sel), .addr(addr), .strobe_n(strobe_n), .dq(dq_i));
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [SSB_DATA_W-1:0] seen, input logic [SSB_DATA_W-1:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   function automatic logic [SSB_DATA_W-1:0] rnd();
      return SSB_DATA_W'({$random(seed), $random(seed)});
   endfunction
   task automatic wr(input logic [SSB_ADDR_W-1:0] a, input logic [SSB_DATA_W-1:0] d0,
                     input logic [SSB_DATA_W-1:0] d1, input logic [3:0] s0, input logic [3:0] s1);
      for (int i = 0; i < 4; i++) begin
         if (!s0[i]) ref_mem[a][9*i +: 9] = d0[9*i +: 9];
         if (!s1[i]) ref_mem[a ^ 21'h1][9*i +: 9] = d1[9*i +: 9];
      end
      i_ctrl.burst(1'h0, 1'h0, a, d0, d1, s0, s1);
   endtask
   task automatic rd(input logic [SSB_ADDR_W-1:0] a);
      exp_q.push_back(ref_mem[a]);
      exp_q.push_back(ref_mem[a ^ 21'h1]);
      i_ctrl.burst(1'h0, 1'h1, a, '0, '0, 4'hf, 4'hf);
   endtask
   task automatic drain(input string name);
      for (int i = 0; i < 200 && exp_q.size() != 0; i++) @(posedge clk);
      if (exp_q.size() != 0) begin
         miscompares++;
         conclude();
      end
      repeat (16) @(posedge clk);
      $display("test %s done", name);
   endtask
   // ------------------------------------------------------------
   // monitor: a beat shows one clk after each output strobe
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (stb_q === 1'h1) begin
         check(echo, tru_q);
         check(echo_n, !tru_q);
         if (dq_oe_n === 1'h0) begin
            if (exp_q.size() == 0) check(dq_oe_n, 1'h1);
            else check(dq_o, exp_q.pop_front());
         end
      end
      stb_q = och ? (k_rise | kn_rise) : (c_rise | cn_rise);
      tru_q = och ? k_rise : c_rise;
   end
   initial begin
      #400000;
      miscompares++;
      conclude();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {sys_rst, run, och, stb_q, tru_q} = 5'h10;
      repeat (10) @(posedge clk);
      sys_rst <= 1'h0;
      @(posedge clk);
      check(dq_oe_n, 1'h1);
      check(dq_o, '0);
      check({echo, echo_n}, 2'h1);
      run <= 1'h1;
      a0 = SSB_ADDR_W'($random(seed)) & 21'h1ffffe;
      // write and reads with an empty slot between, even and odd start
      wr(a0, rnd(), rnd(), 4'h0, 4'h0);
      rd(a0);
      rd(a0 | 21'h1);
      drain("burst");
      // one lane per first beat, second beat aborted
      for (int i = 0; i < 4; i++) begin
         wr(a0, rnd(), rnd(), ~(4'h1 << i), 4'hf);
         rd(a0);
      end
      drain("lanes");
      // idle slots carry random select and data at address a0 that must be ignored
      for (int i = 0; i < 4; i++)
         i_ctrl.burst(1'h1, 1'($random(seed)), a0, rnd(), rnd(), 4'h0, 4'h0);
      check(dq_oe_n, 1'h1);
      rd(a0);
      drain("idle");
      och <= 1'h1;
      wr(a0, rnd(), rnd(), 4'h0, 4'h3);
      rd(a0 ^ 21'h1);
      drain("single clock");
      och <= 1'h0;
      rd(a0);
      repeat (60) @(posedge clk);
      run <= 1'h0;
      repeat (4) @(posedge clk);
      snap = dq_o;
      d = {dq_oe_n, echo, echo_n};
      repeat (20) begin
         @(posedge clk);
         check(dq_o, snap);
         check({dq_oe_n, echo, echo_n}, d);
      end
      run <= 1'h1;
      drain("clock stop");
      conclude();
   end
endmodule // tb
`default_nettype wire
